// ===== rtl/afeenl_dev.sv
// Device end: LED gating, CO switch control, line pass-through and
// receiver filter, bias and oscillator enables.
// Assumes host-side pins are synchronous to pclk; the comparator is not.
//
// Contract
// - LED sink runs only with pin and gate
// - Select bit routes pulse to driver A/B
// - General-purpose pin may enable either driver
// - Eight-bit current code, four compensation settings
// - Sense voltage bin readable at offset zero
// - Host writes codes before enabling driver
// - Host keeps pulses short, duty low
// - CO resistors disconnect independently
// - CO gain resistor follows gain bits
// - Never both CO references at once
// - CO test switch only without photo reference
// - Transmit outputs follow host inputs when enabled
// - Receiver synchronized to 32 kHz, then deglitched
// - Hysteresis and deglitch from register fields
// - Bias on when any listed block enabled
// - Oscillator on only with photo input amp
// - Mux bypass keeps bias request
// - LED regulator voltage from register field
// - Photo reference 50 mV only when selected, amp on
`timescale 1ns/1ps
module afeenl_dev
    import afeenl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host pins
    afeenl_if.dev pins,
    // Analog side
    input wire logic line_rx_comp,
    input wire logic [1:0] bin_strap,
    output logic led_a_on,
    output logic led_b_on,
    output logic [CODE_W-1:0] led_a_code,
    output logic [CODE_W-1:0] led_b_code,
    output logic [1:0] led_a_tc,
    output logic [1:0] led_b_tc,
    output logic [3:0] led_ldo_voltage,
    output logic [2:0] co_sw_closed,
    output logic [1:0] co_gain,
    output logic [1:0] co_mv_level,
    output logic co_mv_on,
    output logic co_ref300_on,
    output logic co_pullup_on,
    output logic co_pulldown_on,
    output logic photo_ref_50mv,
    output logic line_tx_out_1,
    output logic line_tx_out_2,
    output logic [1:0] line_rx_hys,
    output logic bias_enable,
    output logic osc_enable
);
    typedef struct packed {
        logic [10:0] div;
        logic sync1;
        logic sync2;
        logic [3:0] cnt;
        logic filt;
        logic [1:0] bin;
        logic bin_taken;
        logic [CODE_W-1:0] code_a;
        logic [CODE_W-1:0] code_b;
        logic [1:0] tc_a;
        logic [1:0] tc_b;
        logic [3:0] ldo_v;
        logic [2:0] co_sw;
        logic [1:0] co_gain;
        logic [1:0] co_mv;
        logic [1:0] rx_hys;
    } afeenl_dev_st_t;

    afeenl_dev_st_t st_reg, st_next;
    logic tick;
    logic pulse_a, pulse_b, gpio_a, gpio_b;

    function automatic logic [3:0] deg_len(input logic [1:0] code);
        unique case (code)
            2'h0: deg_len = DEG_TICKS_0;
            2'h1: deg_len = DEG_TICKS_1;
            2'h2: deg_len = DEG_TICKS_2;
            2'h3: deg_len = DEG_TICKS_3;
        endcase
    endfunction

    assign tick = (st_reg.div == LINE_DIV_LAST);

    always_comb begin
        st_next = st_reg;
        st_next.div = tick ? 11'h000 : st_reg.div + 11'h001;
        // Settings held in flops so the analog side never sees decode glitches
        st_next.code_a = pins.led_a_current_code;
        st_next.code_b = pins.led_b_current_code;
        st_next.tc_a = pins.led_a_temp_comp;
        st_next.tc_b = pins.led_b_temp_comp;
        st_next.ldo_v = pins.led_reg_voltage;
        st_next.co_sw = pins.co_resistor_switches;
        st_next.co_gain = pins.co_gain_select;
        st_next.co_mv = pins.co_millivolt_ref;
        st_next.rx_hys = pins.line_rx_hysteresis;
        // Strap caught after reset release, not in reset
        if (!st_reg.bin_taken) begin
            st_next.bin = bin_strap;
            st_next.bin_taken = 1'b1;
        end
        if (tick) begin
            st_next.sync1 = line_rx_comp;
            st_next.sync2 = st_reg.sync1;
            if (st_reg.sync2 == st_reg.filt) begin
                st_next.cnt = 4'h0;
            end else if (st_reg.cnt + 4'h1 >= deg_len(pins.line_rx_deglitch)) begin
                st_next.filt = st_reg.sync2;
                st_next.cnt = 4'h0;
            end else begin
                st_next.cnt = st_reg.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{
                div: 11'h000,
                sync1: 1'b0,
                sync2: 1'b0,
                cnt: 4'h0,
                filt: 1'b0,
                bin: BIN_RESET,
                bin_taken: 1'b0,
                code_a: '0,
                code_b: '0,
                tc_a: 2'h0,
                tc_b: 2'h0,
                ldo_v: 4'h0,
                co_sw: 3'h0,
                co_gain: 2'h0,
                co_mv: 2'h0,
                rx_hys: 2'h0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins.sense_voltage_bin = st_reg.bin;
    assign pins.line_rx_out = st_reg.filt;
    assign line_rx_hys = st_reg.rx_hys;

    // Pin pulse gated by the gate bit, routed by the select bit
    assign pulse_a = pins.led_pulse_pin & pins.led_pin_gate_bit & ~pins.led_driver_select;
    assign pulse_b = pins.led_pulse_pin & pins.led_pin_gate_bit & pins.led_driver_select;
    // Gpio enable still needs the gate bit
    assign gpio_a = pins.gpio_led_enable & ~pins.gpio_led_select & pins.gpio_pin
                    & pins.led_pin_gate_bit;
    assign gpio_b = pins.gpio_led_enable & pins.gpio_led_select & pins.gpio_pin
                    & pins.led_pin_gate_bit;
    assign led_a_on = pulse_a | gpio_a;
    assign led_b_on = pulse_b | gpio_b;
    assign led_a_code = st_reg.code_a;
    assign led_b_code = st_reg.code_b;
    assign led_a_tc = st_reg.tc_a;
    assign led_b_tc = st_reg.tc_b;
    assign led_ldo_voltage = st_reg.ldo_v;

    assign co_sw_closed = st_reg.co_sw;
    assign co_gain = st_reg.co_gain;
    assign co_mv_level = st_reg.co_mv;
    // 300 mV reference wins if both requested
    assign co_ref300_on = pins.co_ref300_enable;
    assign co_mv_on = pins.co_mv_ref_enable & ~pins.co_ref300_enable;
    assign photo_ref_50mv = pins.photo_ref_select
                            & (pins.photo_input_amp_enable | pins.photo_gain_amp_enable);
    // Test switch blocked while photo amp uses the pin
    assign co_pulldown_on = pins.co_test_enable & ~pins.co_test_direction
                            & ~photo_ref_50mv;
    assign co_pullup_on = pins.co_test_enable & pins.co_test_direction
                          & ~photo_ref_50mv;

    assign line_tx_out_1 = pins.line_tx_enable & pins.host_tx_in_1;
    assign line_tx_out_2 = pins.line_tx_enable & pins.host_tx_in_2;

    // Mux bypass deliberately not in this term
    assign bias_enable = pins.photo_input_amp_enable | (pins.analog_mux_select != 3'h0)
                         | pins.led_regulator_enable | pins.photo_gain_amp_enable
                         | led_a_on | led_b_on | pins.overtemp_monitor_enable
                         | pins.line_tx_enable;
    assign osc_enable = pins.photo_input_amp_enable;
endmodule

// ===== rtl/afeenl_host.sv
// Microcontroller end: APB registers drive the AFE control pins.
// Assumes an APB master on pclk; slave answers with no wait state.
`timescale 1ns/1ps
module afeenl_host
    import afeenl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    afeenl_if.host pins
);
    typedef struct packed {
        logic [15:0] led;
        logic [15:0] codes;
        logic [10:0] co;
        logic [11:0] en;
        logic [7:0] line;
    } afeenl_host_st_t;

    afeenl_host_st_t st_reg, st_next;
    logic wr, hit;
    logic [31:0] rd;

    assign wr = psel & penable & pwrite;

    always_comb begin
        st_next = st_reg;
        rd = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr)
            OFS_BIN: rd = {30'h0, pins.sense_voltage_bin};
            OFS_LED: rd = {16'h0, st_reg.led};
            OFS_CODES: rd = {16'h0, st_reg.codes};
            OFS_CO: rd = {21'h0, st_reg.co};
            OFS_EN: rd = {20'h0, st_reg.en};
            OFS_LINE: rd = {24'h0, st_reg.line};
            OFS_STAT: rd = {31'h0, pins.line_rx_out};
            default: hit = 1'b0;
        endcase
        if (wr) begin
            unique case (paddr)
                OFS_LED: st_next.led = pwdata[15:0];
                OFS_CODES: st_next.codes = pwdata[15:0];
                OFS_CO: st_next.co = pwdata[10:0];
                OFS_EN: st_next.en = pwdata[11:0];
                OFS_LINE: st_next.line = pwdata[7:0];
                default: st_next = st_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = (psel & ~pwrite) ? rd : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    assign pins.led_pulse_pin = st_reg.led[LED_PULSE];
    assign pins.led_pin_gate_bit = st_reg.led[LED_GATE];
    assign pins.led_driver_select = st_reg.led[LED_SEL];
    assign pins.gpio_led_enable = st_reg.led[LED_GPIO_EN];
    assign pins.gpio_led_select = st_reg.led[LED_GPIO_SEL];
    assign pins.gpio_pin = st_reg.led[LED_GPIO_LVL];
    assign pins.led_a_temp_comp = st_reg.led[LED_TCA +: 2];
    assign pins.led_b_temp_comp = st_reg.led[LED_TCB +: 2];
    assign pins.led_reg_voltage = st_reg.led[LED_LDOV +: 4];
    assign pins.led_a_current_code = st_reg.codes[7:0];
    assign pins.led_b_current_code = st_reg.codes[15:8];
    assign pins.co_resistor_switches = st_reg.co[CO_SW +: 3];
    assign pins.co_gain_select = st_reg.co[CO_GAIN +: 2];
    assign pins.co_millivolt_ref = st_reg.co[CO_MVREF +: 2];
    // Both references never driven together
    assign pins.co_mv_ref_enable = st_reg.co[CO_MVEN] & ~st_reg.co[CO_R300];
    assign pins.co_ref300_enable = st_reg.co[CO_R300];
    // Test blocked while photo amp may use the reference pin
    assign pins.co_test_enable = st_reg.co[CO_TEST_EN] & ~st_reg.en[EN_PHOTO_REF_PIN];
    assign pins.co_test_direction = st_reg.co[CO_TEST_DIR];
    assign pins.photo_input_amp_enable = st_reg.en[EN_PAMP];
    assign pins.photo_gain_amp_enable = st_reg.en[EN_PGAIN];
    assign pins.led_regulator_enable = st_reg.en[EN_LDO];
    assign pins.overtemp_monitor_enable = st_reg.en[EN_OTS];
    assign pins.line_tx_enable = st_reg.en[EN_TX];
    assign pins.photo_ref_select = st_reg.en[EN_PHOTO_REF_PIN];
    assign pins.analog_mux_select = st_reg.en[EN_MUX +: 3];
    assign pins.mux_bypass = st_reg.en[EN_MUXBYP];
    assign pins.host_tx_in_1 = st_reg.line[LN_TX1];
    assign pins.host_tx_in_2 = st_reg.line[LN_TX2];
    assign pins.line_rx_hysteresis = st_reg.line[LN_HYS +: 2];
    assign pins.line_rx_deglitch = st_reg.line[LN_DEG +: 2];
endmodule

// ===== rtl/afeenl_if.sv
// Pins between the microcontroller end and the AFE control end.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface afeenl_if;
    import afeenl_pkg::*;
    logic led_pulse_pin;
    logic gpio_pin;
    logic led_pin_gate_bit;
    logic led_driver_select;
    logic gpio_led_enable;
    logic gpio_led_select;
    logic [CODE_W-1:0] led_a_current_code;
    logic [CODE_W-1:0] led_b_current_code;
    logic [1:0] led_a_temp_comp;
    logic [1:0] led_b_temp_comp;
    logic [3:0] led_reg_voltage;
    logic [2:0] co_resistor_switches;
    logic [1:0] co_gain_select;
    logic [1:0] co_millivolt_ref;
    logic co_mv_ref_enable;
    logic co_ref300_enable;
    logic co_test_enable;
    logic co_test_direction;
    logic photo_input_amp_enable;
    logic photo_gain_amp_enable;
    logic led_regulator_enable;
    logic overtemp_monitor_enable;
    logic line_tx_enable;
    logic photo_ref_select;
    logic [2:0] analog_mux_select;
    logic mux_bypass;
    logic host_tx_in_1;
    logic host_tx_in_2;
    logic [1:0] line_rx_hysteresis;
    logic [1:0] line_rx_deglitch;
    logic [1:0] sense_voltage_bin;
    logic line_rx_out;
    modport dev (
        input led_pulse_pin, gpio_pin, led_pin_gate_bit, led_driver_select,
        input gpio_led_enable, gpio_led_select, led_a_current_code,
        input led_b_current_code, led_a_temp_comp, led_b_temp_comp, led_reg_voltage,
        input co_resistor_switches, co_gain_select, co_millivolt_ref,
        input co_mv_ref_enable, co_ref300_enable, co_test_enable, co_test_direction,
        input photo_input_amp_enable, photo_gain_amp_enable, led_regulator_enable,
        input overtemp_monitor_enable, line_tx_enable, photo_ref_select,
        input analog_mux_select, mux_bypass, host_tx_in_1, host_tx_in_2,
        input line_rx_hysteresis, line_rx_deglitch,
        output sense_voltage_bin, line_rx_out
    );
    modport host (
        output led_pulse_pin, gpio_pin, led_pin_gate_bit, led_driver_select,
        output gpio_led_enable, gpio_led_select, led_a_current_code,
        output led_b_current_code, led_a_temp_comp, led_b_temp_comp, led_reg_voltage,
        output co_resistor_switches, co_gain_select, co_millivolt_ref,
        output co_mv_ref_enable, co_ref300_enable, co_test_enable, co_test_direction,
        output photo_input_amp_enable, photo_gain_amp_enable, led_regulator_enable,
        output overtemp_monitor_enable, line_tx_enable, photo_ref_select,
        output analog_mux_select, mux_bypass, host_tx_in_1, host_tx_in_2,
        output line_rx_hysteresis, line_rx_deglitch,
        input sense_voltage_bin, line_rx_out
    );
endinterface

// ===== rtl/afeenl_pkg.sv
// Package for the AFE enable and line control block.
// Assumes one 50 MHz clock, pclk, shared by both ends.
package afeenl_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int LINE_CLK_HZ = 32768;
    // 32 kHz tick divider
    localparam int LINE_DIV = CLK_HZ / LINE_CLK_HZ;
    localparam logic [10:0] LINE_DIV_LAST = 11'(LINE_DIV - 1);
    // Deglitch lengths in 32 kHz ticks, per code
    localparam logic [3:0] DEG_TICKS_0 = 4'h1;
    localparam logic [3:0] DEG_TICKS_1 = 4'h2;
    localparam logic [3:0] DEG_TICKS_2 = 4'h4;
    localparam logic [3:0] DEG_TICKS_3 = 4'h8;
    // Config word layout (host to device)
    localparam int CODE_W = 8;
    localparam logic [1:0] BIN_RESET = 2'h0;
    // Host register offsets on APB
    localparam logic [7:0] OFS_BIN = 8'h00;
    localparam logic [7:0] OFS_LED = 8'h04;
    localparam logic [7:0] OFS_CODES = 8'h08;
    localparam logic [7:0] OFS_CO = 8'h0c;
    localparam logic [7:0] OFS_EN = 8'h10;
    localparam logic [7:0] OFS_LINE = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    // LED register fields
    localparam int LED_PULSE = 0;
    localparam int LED_GATE = 1;
    localparam int LED_SEL = 2;
    localparam int LED_GPIO_EN = 3;
    localparam int LED_GPIO_SEL = 4;
    localparam int LED_GPIO_LVL = 5;
    localparam int LED_TCA = 8;
    localparam int LED_TCB = 10;
    localparam int LED_LDOV = 12;
    // CO register fields
    localparam int CO_SW = 0;
    localparam int CO_GAIN = 3;
    localparam int CO_MVREF = 5;
    localparam int CO_MVEN = 7;
    localparam int CO_R300 = 8;
    localparam int CO_TEST_EN = 9;
    localparam int CO_TEST_DIR = 10;
    // Enable register fields
    localparam int EN_PAMP = 0;
    localparam int EN_PGAIN = 1;
    localparam int EN_LDO = 2;
    localparam int EN_OTS = 3;
    localparam int EN_TX = 4;
    localparam int EN_PHOTO_REF_PIN = 5;
    localparam int EN_MUX = 8;
    localparam int EN_MUXBYP = 11;
    // Line register fields
    localparam int LN_TX1 = 0;
    localparam int LN_TX2 = 1;
    localparam int LN_HYS = 4;
    localparam int LN_DEG = 6;
endpackage

// ===== verif/afe_enable_and_line_control_tb.sv
// Bench joining host and device ends; drives APB and the comparator.
// Assumes the package constants and a 50 MHz pclk.
`timescale 1ns/1ps
module afe_enable_and_line_control_tb;
    import afeenl_pkg::*;
    localparam logic [1:0] BIN_STRAP = 2'h2;
    localparam int TMO = 98000;
    localparam logic [7:0] OFS[5] = '{OFS_CODES, OFS_CO, OFS_EN, OFS_LINE, OFS_LED};
    // Bits each host register keeps, in the order of OFS
    localparam logic [31:0] WR_MASK[5] = '{32'h0000_ffff, 32'h0000_07ff, 32'h0000_0fff,
        32'h0000_00ff, 32'h0000_ffff};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_rx_comp, err;
    logic [7:0] paddr, led_a_code, led_b_code;
    logic [31:0] pwdata, prdata, rd, w[5];
    logic led_a_on, led_b_on, co_mv_on, co_ref300_on, co_pullup_on, co_pulldown_on;
    logic photo_ref_50mv, line_tx_out_1, line_tx_out_2, bias_enable, osc_enable;
    logic [1:0] led_a_tc, led_b_tc, co_gain, co_mv_level, line_rx_hys;
    logic [3:0] led_ldo_voltage;
    logic [2:0] co_sw_closed;
    int error_cnt, samples_checked, cyc, n;

    afeenl_if pins();
    afeenl_host i_afeenl_host(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pins(pins));
    afeenl_dev i_afeenl_dev(.pclk, .presetn, .pins(pins), .line_rx_comp,
        .bin_strap(BIN_STRAP), .led_a_on, .led_b_on, .led_a_code, .led_b_code, .led_a_tc,
        .led_b_tc, .led_ldo_voltage, .co_sw_closed, .co_gain, .co_mv_level, .co_mv_on,
        .co_ref300_on, .co_pullup_on, .co_pulldown_on, .photo_ref_50mv, .line_tx_out_1,
        .line_tx_out_2, .line_rx_hys, .bias_enable, .osc_enable);
    afeenl_chk i_afeenl_chk(.pclk, .presetn, .led_pulse_pin(pins.led_pulse_pin),
        .led_pin_gate_bit(pins.led_pin_gate_bit), .led_driver_select(pins.led_driver_select),
        .co_mv_ref_enable(pins.co_mv_ref_enable), .co_ref300_enable(pins.co_ref300_enable),
        .photo_input_amp_enable(pins.photo_input_amp_enable),
        .line_tx_enable(pins.line_tx_enable), .host_tx_in_1(pins.host_tx_in_1),
        .host_tx_in_2(pins.host_tx_in_2), .line_rx_out(pins.line_rx_out), .line_rx_comp,
        .led_a_on, .led_b_on, .co_mv_on, .co_ref300_on, .co_pullup_on, .co_pulldown_on,
        .photo_ref_50mv, .line_tx_out_1, .line_tx_out_2, .bias_enable, .osc_enable,
        .analog_mux_select(pins.analog_mux_select), .mux_bypass(pins.mux_bypass));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waits on pready without a local limit; the cycle ceiling ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // w holds codes, CO, enables, line and LED words
    task automatic check_dev();
        logic a, b, t;
        a = w[4][LED_GATE] & ((w[4][LED_PULSE] & !w[4][LED_SEL]) |
            (w[4][LED_GPIO_EN] & w[4][LED_GPIO_LVL] & !w[4][LED_GPIO_SEL]));
        b = w[4][LED_GATE] & ((w[4][LED_PULSE] & w[4][LED_SEL]) |
            (w[4][LED_GPIO_EN] & w[4][LED_GPIO_LVL] & w[4][LED_GPIO_SEL]));
        t = w[1][CO_TEST_EN] & !w[2][EN_PHOTO_REF_PIN];
        chk("led", 32'({a, b}), 32'({led_a_on, led_b_on}));
        chk("codes", 32'(w[0][15:0]), 32'({led_b_code, led_a_code}));
        chk("cfg", 32'({w[4][15:8], w[1][2:0], w[1][4:3], w[1][6:5], w[3][5:4]}),
            32'({led_ldo_voltage, led_b_tc, led_a_tc, co_sw_closed, co_gain, co_mv_level,
            line_rx_hys}));
        chk("refs", 32'({w[1][CO_MVEN] & !w[1][CO_R300], w[1][CO_R300], t & w[1][CO_TEST_DIR],
            t & !w[1][CO_TEST_DIR], w[2][EN_PHOTO_REF_PIN] & (w[2][EN_PAMP] | w[2][EN_PGAIN])}),
            32'({co_mv_on, co_ref300_on, co_pullup_on, co_pulldown_on,
            photo_ref_50mv}));
        chk("tx", 32'({2{w[2][EN_TX]}} & w[3][1:0]),
            32'({line_tx_out_2, line_tx_out_1}));
        chk("bias", 32'({a | b | (w[2][10:8] != 3'h0) | (w[2][4:0] != 5'h0), w[2][EN_PAMP]}),
            32'({bias_enable, osc_enable}));
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc >= TMO) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, line_rx_comp} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(51));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_BIN, 32'h0);
        chk("bin", 32'(BIN_STRAP), rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, 32'(err));
        $display("test registers done");
        for (int i = 0; i < 20; i++) begin
            for (int k = 0; k < 5; k++) begin
                w[k] = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
                apb(1'b1, OFS[k], w[k]);
            end
            @(posedge pclk);
            #1;
            check_dev();
            apb(1'b0, OFS[i % 5], 32'h0);
            chk("readback", w[i % 5] & WR_MASK[i % 5], rd);
            apb(1'b1, OFS_LED, 32'h0);
            // Long rest keeps the LED duty under one percent
            repeat (800) @(posedge pclk);
        end
        $display("test outputs done");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_LINE, 32'(c) << LN_DEG);
            repeat ($urandom % LINE_DIV) @(posedge pclk);
            line_rx_comp <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pins.line_rx_out !== 1'b1 && n < (4 + (1 << c)) * LINE_DIV);
            chk("rise", 32'h1, 32'(n >= (1 + (1 << c)) * LINE_DIV &&
                n <= (3 + (1 << c)) * LINE_DIV));
            apb(1'b0, OFS_STAT, 32'h0);
            chk("status", 32'h1, rd);
            apb(1'b1, OFS_LINE, 32'h0);
            line_rx_comp <= 1'b0;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pins.line_rx_out !== 1'b0 && n < 5 * LINE_DIV);
            chk("fall", 32'h0, 32'(pins.line_rx_out));
        end
        apb(1'b1, OFS_LINE, 32'hc0);
        line_rx_comp <= 1'b1;
        repeat (4 * LINE_DIV) @(posedge pclk);
        line_rx_comp <= 1'b0;
        n = 0;
        repeat (6 * LINE_DIV) begin
            @(posedge pclk);
            if (pins.line_rx_out !== 1'b0) n++;
        end
        chk("glitch", 32'h0, 32'(n));
        $display("test line receive done");
        give_verdict();
    end
endmodule

// ===== verif/afeenl_chk.sv
// Assertions on the pins joining both ends and on the device outputs.
// Assumes one clock, pclk, and asynchronous active-low presetn.
`timescale 1ns/1ps
module afeenl_chk
    import afeenl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Interface pins
    input wire logic led_pulse_pin,
    input wire logic led_pin_gate_bit,
    input wire logic led_driver_select,
    input wire logic co_mv_ref_enable,
    input wire logic co_ref300_enable,
    input wire logic photo_input_amp_enable,
    input wire logic [2:0] analog_mux_select,
    input wire logic mux_bypass,
    input wire logic line_tx_enable,
    input wire logic host_tx_in_1,
    input wire logic host_tx_in_2,
    input wire logic line_rx_out,
    // Device side
    input wire logic line_rx_comp,
    input wire logic led_a_on,
    input wire logic led_b_on,
    input wire logic co_mv_on,
    input wire logic co_ref300_on,
    input wire logic co_pullup_on,
    input wire logic co_pulldown_on,
    input wire logic photo_ref_50mv,
    input wire logic line_tx_out_1,
    input wire logic line_tx_out_2,
    input wire logic bias_enable,
    input wire logic osc_enable
);
    // Four ticks low flush the two-stage synchroniser whatever the phase
    localparam int RX_QUIET = 4 * LINE_DIV;
    logic [12:0] low_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run <= 13'h0;
        end else if (line_rx_comp) begin
            low_run <= 13'h0;
        end else if (low_run != 13'h1fff) begin
            low_run <= low_run + 13'h1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence comp_quiet;
        low_run >= 13'(RX_QUIET);
    endsequence
    sequence rx_no_rise;
        !$rose(line_rx_out);
    endsequence

    rx_quiet_a: assert property (comp_quiet |=> rx_no_rise)
        else $error("receiver rose while comparator was quiet");
    led_gate_a: assert property ((led_a_on || led_b_on) |-> led_pin_gate_bit)
        else $error("led sink on without gate bit");
    led_route_a: assert property ((led_pulse_pin && led_pin_gate_bit) |->
        (led_driver_select ? led_b_on : led_a_on)) else $error("led pulse not routed");
    ref_pins_a: assert property (!(co_mv_ref_enable && co_ref300_enable))
        else $error("both reference requests on the pins");
    ref_dev_a: assert property (co_ref300_on |-> !co_mv_on)
        else $error("both references on");
    co_test_a: assert property ((co_pullup_on || co_pulldown_on) |->
        (!photo_ref_50mv && !(co_pullup_on && co_pulldown_on))) else $error("test switch bad");
    tx_follow_a: assert property (line_tx_enable |->
        (line_tx_out_1 == host_tx_in_1 && line_tx_out_2 == host_tx_in_2))
        else $error("transmit outputs do not follow");
    tx_off_a: assert property (!line_tx_enable |-> !(line_tx_out_1 || line_tx_out_2))
        else $error("transmit output active while disabled");
    osc_only_a: assert property (osc_enable == photo_input_amp_enable)
        else $error("oscillator enable wrong");
    bypass_bias_a: assert property ((mux_bypass && analog_mux_select != 3'h0) |-> bias_enable)
        else $error("bias off with bypassed mux selected");
endmodule
